// ### verilog/shbgp_pkg.sv
// shared constants for the synchronous 16-bit host bus port
// assumes: one design module imports it whole
package shbgp_pkg;
  // ----------------------------------------
  // clocking and timing
  // ----------------------------------------
  localparam int SYS_CLK_MHZ = 250;
  localparam int MIN_CYCLE_BUS_CLKS = 2; // least bus clocks from start to acknowledge
  // ----------------------------------------
  // address map
  // ----------------------------------------
  localparam int ADDR_W = 18; // 256K byte block
  localparam int DATA_W = 16;
  localparam int REG_IDX_W = 6; // register block words held in flip-flops
  localparam int BUF_IDX_W = 8; // display buffer words held in flip-flops
  localparam logic [DATA_W-1:0] REG_RESET_VAL = 16'h0000;
  // ----------------------------------------
  // host mode straps (4 bits: mode field, all 4 bits compared, no reserved bit)
  // ----------------------------------------
  localparam int MODE_W = 4;
  localparam logic [MODE_W-1:0] MODE_GENERIC_ONE = 4'hb;
  localparam int STALL_W = 4;
  localparam logic [STALL_W-1:0] STALL_INIT = 4'h0;
  // ----------------------------------------
  // access states, one-hot
  // ----------------------------------------
  typedef enum logic [3:0] {
    SHBGP_IDLE = 4'h1,
    SHBGP_WAIT = 4'h2,
    SHBGP_ACK = 4'h4,
    SHBGP_DONE = 4'h8
  } shbgp_state_e;
endpackage

// ### verilog/shbgp_port.sv
// 16-bit synchronous host bus port of the display controller, slave side
// assumes: bus pins are timed to bus_reference_clock; clk_sys is the internal
// arbitration clock; the master keeps its own half of the bus protocol
//
// Contract
// - slave ends each transfer with a single-clock acknowledge, wait released for one clock at the inverse of the strap's level
// - no transaction completes in fewer than two bus clocks
// - port is 16 bits with one select and per-byte read and write strobes
// - host mode is latched at reset release and applied afterwards
// - wait holds the host until read data is valid or write accepted
// - memory-or-register select steers to registers or display buffer
// - wait polarity strap: high gives active-high wait, low active-low
`timescale 1ns/1ps
module shbgp_port
  import shbgp_pkg::*;
#(
  parameter int REG_WORDS = 64,
  parameter int BUF_WORDS = 256
) (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic bus_reference_clock,
  input wire logic [MODE_W-1:0] strap_host_mode,
  input wire logic strap_wait_polarity,
  input wire logic chip_select_n,
  input wire logic mem_not_reg,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic low_byte_read_n,
  input wire logic high_byte_read_n,
  input wire logic low_byte_write_n,
  input wire logic high_byte_write_n,
  input wire logic [DATA_W-1:0] data_in,
  output logic [DATA_W-1:0] data_out,
  output logic data_oe,
  output logic wait_out,
  input wire logic refresh_busy,
  output logic mode_valid
);
  // ----------------------------------------
  // link side state on bus_reference_clock
  // ----------------------------------------
  typedef struct packed {
    shbgp_state_e st;
    logic req_tgl;
    logic ack_s1;
    logic ack_s2;
    logic is_write;
    logic is_mem;
    logic [1:0] lanes;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic [DATA_W-1:0] rdata;
    logic wait_asserted;
    logic oe;
    logic [MODE_W-1:0] mode;
    logic mode_ok;
    logic rst_seen;
  } shbgp_link_s;

  // ----------------------------------------
  // core side state on clk_sys
  // ----------------------------------------
  typedef struct packed {
    logic req_s1;
    logic req_s2;
    logic req_s3;
    logic ack_tgl;
    logic busy_s1;
    logic busy_s2;
    logic [STALL_W-1:0] stall;
    logic pending;
    logic [DATA_W-1:0] rdata;
  } shbgp_core_s;

  shbgp_link_s l_r, l_nxt;
  shbgp_core_s c_r, c_nxt;
  logic [DATA_W-1:0] regs_r [REG_WORDS];
  logic [DATA_W-1:0] dbuf_r [BUF_WORDS];

  // byte-lane merge used for both storage arrays
  function automatic logic [DATA_W-1:0] merge_lanes(input logic [DATA_W-1:0] old,
                                                    input logic [DATA_W-1:0] nw,
                                                    input logic [1:0] lanes);
    merge_lanes = old;
    if (lanes[0]) merge_lanes[7:0] = nw[7:0];
    if (lanes[1]) merge_lanes[15:8] = nw[15:8];
  endfunction

  // word index from a byte address on a 16-bit port
  function automatic logic [ADDR_W-2:0] word_index(input logic [ADDR_W-1:0] a);
    word_index = a[ADDR_W-1:1];
  endfunction

  logic access_start;
  logic any_read;
  logic any_write;
  assign any_read = !low_byte_read_n || !high_byte_read_n;
  assign any_write = !low_byte_write_n || !high_byte_write_n;
  assign access_start = !chip_select_n && (any_read || any_write);

  // ----------------------------------------
  // link side next state
  // ----------------------------------------
  always_comb begin
    l_nxt = l_r;
    l_nxt.ack_s1 = c_r.ack_tgl;
    l_nxt.ack_s2 = l_r.ack_s1;
    // mode is caught on the first link edge after reset release
    if (!l_r.rst_seen) begin
      l_nxt.rst_seen = 1'b1;
      l_nxt.mode = strap_host_mode;
      l_nxt.mode_ok = (strap_host_mode == MODE_GENERIC_ONE);
    end
    case (l_r.st)
      SHBGP_IDLE: begin
        l_nxt.oe = 1'b0;
        if (l_r.mode_ok && access_start) begin
          l_nxt.is_write = any_write;
          l_nxt.is_mem = mem_not_reg;
          l_nxt.lanes = any_write ? {!high_byte_write_n, !low_byte_write_n}
                                  : {!high_byte_read_n, !low_byte_read_n};
          l_nxt.addr = addr;
          l_nxt.wdata = data_in;
          l_nxt.req_tgl = !l_r.req_tgl;
          l_nxt.wait_asserted = 1'b1;
          l_nxt.st = SHBGP_WAIT;
        end
      end
      SHBGP_WAIT: begin
        // core answered; the start edge plus this edge give two clocks at least
        if (l_r.ack_s2 == l_r.req_tgl) begin
          l_nxt.rdata = c_r.rdata;
          l_nxt.oe = !l_r.is_write;
          l_nxt.wait_asserted = 1'b0;
          l_nxt.st = SHBGP_ACK;
        end
      end
      SHBGP_ACK: begin
        // acknowledge stands one clock only
        l_nxt.wait_asserted = 1'b1;
        l_nxt.st = SHBGP_DONE;
      end
      SHBGP_DONE: begin
        // wait for the strobes to go away so one access gives one acknowledge
        l_nxt.oe = 1'b0;
        if (!access_start) begin
          l_nxt.wait_asserted = 1'b0;
          l_nxt.st = SHBGP_IDLE;
        end
      end
      default: l_nxt.st = SHBGP_IDLE;
    endcase
  end

  // link registers; constants only under reset
  always_ff @(posedge bus_reference_clock or negedge nrst) begin
    if (!nrst) begin
      l_r <= '{st: SHBGP_IDLE, mode: '0, addr: '0, wdata: '0, rdata: '0, lanes: '0, default: 1'b0};
    end else begin
      l_r <= l_nxt;
    end
  end

  // ----------------------------------------
  // core side: crossing, arbitration, storage
  // ----------------------------------------
  logic req_edge;
  logic [ADDR_W-2:0] widx;
  assign req_edge = c_r.req_s2 != c_r.req_s3;
  // link fields stand still from the take until the acknowledge returns, so the core may read them
  assign widx = word_index(l_r.addr);

  always_comb begin
    c_nxt = c_r;
    c_nxt.req_s1 = l_r.req_tgl;
    c_nxt.req_s2 = c_r.req_s1;
    c_nxt.req_s3 = c_r.req_s2;
    c_nxt.busy_s1 = refresh_busy;
    c_nxt.busy_s2 = c_r.busy_s1;
    // refresh holds the resource; the host waits meanwhile
    if (c_r.pending && !c_r.busy_s2) begin
      c_nxt.pending = 1'b0;
      c_nxt.rdata = l_r.is_mem ? dbuf_r[widx[BUF_IDX_W-1:0]] : regs_r[widx[REG_IDX_W-1:0]];
      c_nxt.ack_tgl = c_r.req_s3;
    end
    // a new request wins over the clear of the old one
    if (req_edge) c_nxt.pending = 1'b1;
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      c_r <= '{stall: STALL_INIT, rdata: '0, default: 1'b0};
    end else begin
      c_r <= c_nxt;
    end
  end

  // storage writes; link fields are stable while a request is pending
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      for (int i = 0; i < REG_WORDS; i++) regs_r[i] <= REG_RESET_VAL;
      for (int i = 0; i < BUF_WORDS; i++) dbuf_r[i] <= REG_RESET_VAL;
    end else if (c_r.pending && !c_r.busy_s2 && l_r.is_write) begin
      if (l_r.is_mem) begin
        dbuf_r[widx[BUF_IDX_W-1:0]] <= merge_lanes(dbuf_r[widx[BUF_IDX_W-1:0]], l_r.wdata, l_r.lanes);
      end else begin
        regs_r[widx[REG_IDX_W-1:0]] <= merge_lanes(regs_r[widx[REG_IDX_W-1:0]], l_r.wdata, l_r.lanes);
      end
    end
  end

  // ----------------------------------------
  // pin outputs
  // ----------------------------------------
  // strap high means wait is driven active high
  assign wait_out = l_r.wait_asserted ~^ strap_wait_polarity;
  assign data_out = l_r.rdata;
  assign data_oe = l_r.oe;
  assign mode_valid = l_r.mode_ok;
endmodule

// ### verif/shbgp_port_props.sv
// checker for the host port handshake, sees only the port's pins
// assumes: bound to shbgp_port; hold is wait_out equal to its strap level
`timescale 1ns/1ps
module shbgp_port_props
  import shbgp_pkg::*;
(
  input wire logic bus_reference_clock,
  input wire logic nrst,
  input wire logic strap_wait_polarity,
  input wire logic chip_select_n,
  input wire logic low_byte_read_n,
  input wire logic low_byte_write_n,
  input wire logic high_byte_write_n,
  input wire logic data_oe,
  input wire logic wait_out,
  input wire logic mode_valid
);
  logic hold;
  // acknowledge is a one-cycle gap in hold while still selected
  assign hold = (wait_out == strap_wait_polarity);
  default clocking cb @(posedge bus_reference_clock); endclocking
  default disable iff (!nrst);
  // ----------------------------------------
  // handshake
  // ----------------------------------------
  a_ack_single: assert property ($fell(hold) && !chip_select_n |=> hold)
    else $error("acknowledge longer than one cycle");
  a_min_two_clks: assert property ($fell(hold) && !chip_select_n |-> $past(hold, 2))
    else $error("transfer shorter than two clocks");
  a_mode_gate: assert property (!mode_valid |-> !hold)
    else $error("access taken before mode latched");
  a_mode_kept: assert property (mode_valid |=> mode_valid)
    else $error("latched mode lost");
  a_wait_bounded: assert property (hold && !chip_select_n |-> ##[1:100] !hold)
    else $error("wait never released");
  a_idle_release: assert property (chip_select_n && $past(chip_select_n) |-> !hold)
    else $error("wait held while idle");
  a_read_drives: assert property ($fell(hold) && !chip_select_n && !low_byte_read_n |-> data_oe)
    else $error("read acknowledged without data drive");
  a_write_no_oe: assert property (data_oe |-> $past(low_byte_write_n && high_byte_write_n))
    else $error("data driven during a write");
  c_read_ack: cover property ($fell(hold) && !low_byte_read_n);
  c_write_ack: cover property ($fell(hold) && !low_byte_write_n);
  c_refused: cover property (!mode_valid && !chip_select_n);
endmodule
bind shbgp_port shbgp_port_props u_shbgp_port_props (.bus_reference_clock, .nrst, .strap_wait_polarity,
  .chip_select_n, .low_byte_read_n, .low_byte_write_n, .high_byte_write_n, .data_oe, .wait_out, .mode_valid);

// ### verif/shbgp_host_model.sv
// single-transfer bus master driving the port's pins
// assumes: strobes launched after a link edge, held until the ack is sampled
`timescale 1ns/1ps
module shbgp_host_model
  import shbgp_pkg::*;
(
  input wire logic bus_reference_clock,
  input wire logic wait_out,
  input wire logic strap_wait_polarity,
  input wire logic [DATA_W-1:0] data_out,
  output logic chip_select_n,
  output logic mem_not_reg,
  output logic [ADDR_W-1:0] addr,
  output logic low_byte_read_n,
  output logic high_byte_read_n,
  output logic low_byte_write_n,
  output logic high_byte_write_n,
  output logic [DATA_W-1:0] data_in
);
  // idle bus at time zero
  initial begin
    {chip_select_n, low_byte_read_n, high_byte_read_n, low_byte_write_n, high_byte_write_n} = 5'h1f;
    {mem_not_reg, addr, data_in} = '0;
  end
  // one access; cyc counts edges after the take edge, capped so refusals end
  task automatic xfer(input logic rd, input logic mem, input logic [ADDR_W-1:0] a, input logic [1:0] ln,
    input logic [DATA_W-1:0] wd, output logic [DATA_W-1:0] rdat, output int cyc);
    logic seen;
    @(posedge bus_reference_clock);
    chip_select_n <= 1'h0;
    mem_not_reg <= mem;
    addr <= a;
    data_in <= wd;
    {high_byte_read_n, low_byte_read_n} <= ~(ln & {2{rd}});
    {high_byte_write_n, low_byte_write_n} <= ~(ln & {2{!rd}});
    cyc = 0;
    seen = 1'b0;
    @(posedge bus_reference_clock);
    // a refused access never holds, so only a hold followed by its release counts as an acknowledge
    do begin
      @(posedge bus_reference_clock);
      cyc++;
      if (wait_out === strap_wait_polarity) seen = 1'b1;
    end while (!(seen && wait_out !== strap_wait_polarity) && cyc < 60);
    rdat = data_out;
    {chip_select_n, low_byte_read_n, high_byte_read_n, low_byte_write_n, high_byte_write_n} <= 5'h1f;
    data_in <= ~wd; // released bus must not keep the last value
    repeat (2) @(posedge bus_reference_clock);
  endtask
endmodule

// ### verif/tb_top.sv
// testbench for the host port: register, buffer, lane and stall accesses
// assumes: shbgp_host_model drives the bus; straps and refresh driven here
`timescale 1ns/1ps
module tb_top;
  import shbgp_pkg::*;
  logic clk_sys = 0, bus_reference_clock = 0, nrst = 0, strap_wait_polarity = 0, refresh_busy = 0;
  logic [MODE_W-1:0] strap_host_mode = MODE_GENERIC_ONE;
  logic chip_select_n, mem_not_reg, low_byte_read_n, high_byte_read_n, low_byte_write_n, high_byte_write_n;
  logic data_oe, wait_out, mode_valid;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] data_in, data_out, rd;
  int miscompares = 0, check_count = 0, cyc, tick = 0;
  always #2 clk_sys = ~clk_sys;
  always #62.5 bus_reference_clock = ~bus_reference_clock;
  shbgp_port u_shbgp_port (.clk_sys, .nrst, .bus_reference_clock, .strap_host_mode, .strap_wait_polarity,
    .chip_select_n, .mem_not_reg, .addr, .low_byte_read_n, .high_byte_read_n, .low_byte_write_n,
    .high_byte_write_n, .data_in, .data_out, .data_oe, .wait_out, .refresh_busy, .mode_valid);
  shbgp_host_model u_host (.bus_reference_clock, .wait_out, .strap_wait_polarity, .data_out, .chip_select_n,
    .mem_not_reg, .addr, .low_byte_read_n, .high_byte_read_n, .low_byte_write_n, .high_byte_write_n, .data_in);
  // ----------------------------------------
  // compare and closing tasks
  // ----------------------------------------
  task automatic chk_data(input logic [DATA_W-1:0] g, input logic [DATA_W-1:0] e);
    check_count++;
    if (g !== e) begin
      miscompares++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic chk_bit(input logic g, input logic e);
    check_count++;
    if (g !== e) begin
      miscompares++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic conclude;
    $display("checks=%0d miscompares=%0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // reset long enough for both clocks, straps set beforehand
  task automatic do_reset(input logic [MODE_W-1:0] m, input logic p);
    @(posedge clk_sys);
    nrst <= 1'h0;
    strap_host_mode <= m;
    strap_wait_polarity <= p;
    repeat (20) @(posedge clk_sys);
    repeat (2) @(posedge bus_reference_clock);
    chk_bit(wait_out, !p);
    chk_bit(data_oe, 1'h0);
    @(posedge clk_sys);
    nrst <= 1'h1;
    repeat (3) @(posedge bus_reference_clock);
    chk_bit(mode_valid, m === MODE_GENERIC_ONE);
  endtask
  // hang guard, well above the expected few thousand cycles
  always @(posedge clk_sys) begin
    tick <= tick + 1;
    if (tick == 40000) begin
      miscompares++;
      conclude;
    end
  end
  initial begin
    do_reset(4'h3, 1'h1);
    u_host.xfer(1'h0, 1'h0, 18'h0000, 2'h3, 16'h1234, rd, cyc);
    chk_bit(cyc < 60, 1'h0);
    for (int p = 0; p < 2; p++) begin
      do_reset(MODE_GENERIC_ONE, p[0]);
      @(posedge clk_sys);
      strap_host_mode <= 4'h0; // latched value must survive strap change
      u_host.xfer(1'h0, 1'h0, 18'h007e, 2'h3, 16'ha5c3, rd, cyc);
      chk_bit(cyc >= 3, 1'h1);
      u_host.xfer(1'h0, 1'h1, 18'h007e, 2'h3, 16'h3c5a, rd, cyc);
      u_host.xfer(1'h0, 1'h0, 18'h007e, 2'h2, 16'hffee, rd, cyc);
      u_host.xfer(1'h1, 1'h0, 18'h007e, 2'h3, 16'h0000, rd, cyc);
      chk_data(rd, 16'hffc3);
      u_host.xfer(1'h1, 1'h1, 18'h007e, 2'h3, 16'h0000, rd, cyc);
      chk_data(rd, 16'h3c5a);
      u_host.xfer(1'h0, 1'h1, 18'h01fe, 2'h3, 16'h0f0f, rd, cyc);
      @(posedge clk_sys);
      refresh_busy <= 1'h1;
      fork
        begin
          repeat (400) @(posedge clk_sys);
          refresh_busy <= 1'h0;
        end
      join_none
      u_host.xfer(1'h1, 1'h1, 18'h01fe, 2'h3, 16'h0000, rd, cyc);
      chk_data(rd, 16'h0f0f);
      chk_bit(cyc > 8 && cyc < 60, 1'h1);
    end
    conclude;
  end
endmodule
